// ===== rtl/tac_pkg.sv
// Package of constants for the trace address comparator unit
`default_nettype none
package tac_pkg;
   // ****************************************
   // Sizes
   // ****************************************
   localparam int ADDR_W = 32;
   localparam int NUM_CMP = 16;
   localparam int NUM_PAIR = NUM_CMP / 2;
   localparam int CMP_IDX_W = 4;
   localparam int CTX_W = 2;
   // ****************************************
   // Access-type field layout
   // ****************************************
   localparam int ACC_W = 4;
   localparam int ACC_CTX_LSB = 0;
   localparam int ACC_CTX_EN_BIT = 2;
   localparam int ACC_DIS_BIT = 3;
   localparam logic [ACC_W-1:0] ACC_RST = 4'h0;
   localparam logic [ADDR_W-1:0] VAL_RST = 32'h0000_0000;
   // ****************************************
   // Block end rounding (halfword or word instruction)
   // ****************************************
   localparam logic [ADDR_W-1:0] END_PAD_HALF = 32'h0000_0001;
   localparam logic [ADDR_W-1:0] END_PAD_WORD = 32'h0000_0003;
endpackage : tac_pkg
`default_nettype wire

// ===== rtl/tac_cmp_bank.sv
// Comparator configuration store, with registered read for one comparator
`default_nettype none
module tac_cmp_bank (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cfg_wr,
   input wire logic [tac_pkg::CMP_IDX_W-1:0] cfg_idx,
   input wire logic [tac_pkg::ADDR_W-1:0] cfg_value,
   input wire logic [tac_pkg::ACC_W-1:0] cfg_access,
   output logic [tac_pkg::NUM_CMP*tac_pkg::ADDR_W-1:0] values,
   output logic [tac_pkg::NUM_CMP*tac_pkg::ACC_W-1:0] accesses,
   output logic [tac_pkg::ADDR_W-1:0] rd_value
);
   localparam int AW = tac_pkg::ADDR_W;
   localparam int CW = tac_pkg::ACC_W;

   genvar g;
   generate
      for (g = 0; g < tac_pkg::NUM_CMP; g++) begin : g_cmp
         wire hit = cfg_wr && (int'(cfg_idx) == g);
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               values[g*AW +: AW] <= tac_pkg::VAL_RST;
               accesses[g*CW +: CW] <= tac_pkg::ACC_RST;
            end else if (hit) begin
               values[g*AW +: AW] <= cfg_value;
               accesses[g*CW +: CW] <= cfg_access;
            end
         end
      end
   endgenerate

   // Readback of the last addressed comparator, registered
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_value <= tac_pkg::VAL_RST;
      end else begin
         rd_value <= values[cfg_idx*AW +: AW];
      end
   end
endmodule : tac_cmp_bank
`default_nettype wire

// ===== rtl/tac_top.sv
// Address comparator unit: single-address and range matching per waypoint
//
// Behaviour
// - Sixteen comparators, eight pairs, numbered from one
// - Adjacent comparator pairs form range matchers
// - Comparator serves single and range use together
// - Single match ignores condition code outcome
// - Range match ignores condition code outcome
// - Context match qualifies address match when selected
// - Waypoint target kept as next block start
// - Block end: waypoint or last pre-exception address
// - Block end within last instruction's bytes
// - Wrapped block: range results defined here as none
// - Empty block clears single events, leaves range results unchanged
// - Evaluate all comparators only at waypoints
// - Single match: start <= value <= end
// - Match needs address and access conditions
// - Single match lasts one cycle, the cycle after the waypoint
// - Every value register tested as single matcher
// - Include: low <= end and high > start
// - Exclude: low <= start and high > end
// - Range match held until next non-empty waypoint
// - Processor reset keeps range results
// - Pairs 2n-1,2n evaluated as range matcher n
// - Include/exclude control bit selects range use
`default_nettype none
module tac_top (
   input wire logic sys_clk,
   input wire logic arst_n,
   // Processor side
   input wire logic wp_valid,
   input wire logic [tac_pkg::ADDR_W-1:0] wp_addr,
   input wire logic [tac_pkg::ADDR_W-1:0] wp_target,
   input wire logic wp_exception,
   input wire logic [tac_pkg::ADDR_W-1:0] wp_last_addr,
   input wire logic wp_insn_half,
   input wire logic wp_direct_flow,
   input wire logic wp_empty,
   input wire logic cpu_reset,
   input wire logic [3:0] ctx_match,
   // Debugger programming side
   input wire logic cfg_wr,
   input wire logic [tac_pkg::CMP_IDX_W-1:0] cfg_idx,
   input wire logic [tac_pkg::ADDR_W-1:0] cfg_value,
   input wire logic [tac_pkg::ACC_W-1:0] cfg_access,
   input wire logic [tac_pkg::NUM_PAIR-1:0] range_select,
   input wire logic include_mode,
   output logic [tac_pkg::ADDR_W-1:0] cfg_rd_value,
   // Results
   output logic [tac_pkg::NUM_CMP-1:0] single_address_matcher_ev,
   output logic [tac_pkg::NUM_PAIR-1:0] range_matcher_ev,
   output logic [tac_pkg::NUM_PAIR-1:0] range_exclude_hit,
   output logic trace_gate_range_ok
);
   localparam int AW = tac_pkg::ADDR_W;
   localparam int CW = tac_pkg::ACC_W;
   localparam int NC = tac_pkg::NUM_CMP;
   localparam int NP = tac_pkg::NUM_PAIR;

   // ****************************************
   // Reset synchroniser
   // ****************************************
   logic rst_meta_r;
   logic rst_n_r;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   // ****************************************
   // Comparator configuration
   // ****************************************
   wire [NC*AW-1:0] values;
   wire [NC*CW-1:0] accesses;

   tac_cmp_bank u_bank (
      .sys_clk(sys_clk),
      .rst_n(rst_n_r),
      .cfg_wr(cfg_wr),
      .cfg_idx(cfg_idx),
      .cfg_value(cfg_value),
      .cfg_access(cfg_access),
      .values(values),
      .accesses(accesses),
      .rd_value(cfg_rd_value)
   );

   // Access-type qualifier, used for both single and paired matching
   function automatic logic access_ok(input logic [CW-1:0] acc,
                                      input logic [3:0] ctx);
      logic [1:0] sel;
      sel = acc[tac_pkg::ACC_CTX_LSB +: tac_pkg::CTX_W];
      access_ok = !acc[tac_pkg::ACC_DIS_BIT] &&
                  (!acc[tac_pkg::ACC_CTX_EN_BIT] || ctx[sel]);
   endfunction : access_ok

   // ****************************************
   // Address tests
   // ****************************************
   // Inclusive span test of one programmed value
   function automatic logic in_span(input logic [AW-1:0] v,
                                    input logic [AW-1:0] s,
                                    input logic [AW-1:0] e);
      in_span = (v >= s) && (v <= e);
   endfunction : in_span

   // Range touches the block anywhere
   function automatic logic overlaps(input logic [AW-1:0] lo,
                                     input logic [AW-1:0] hi,
                                     input logic [AW-1:0] s,
                                     input logic [AW-1:0] e);
      overlaps = (lo <= e) && (hi > s);
   endfunction : overlaps

   // Range holds the whole block
   function automatic logic covers(input logic [AW-1:0] lo,
                                   input logic [AW-1:0] hi,
                                   input logic [AW-1:0] s,
                                   input logic [AW-1:0] e);
      covers = (lo <= s) && (hi > e);
   endfunction : covers

   // ****************************************
   // Instruction block bounds
   // ****************************************
   logic [AW-1:0] blk_start_r;
   logic [AW-1:0] prev_wp_r;
   wire [AW-1:0] blk_start_nxt;
   wire [AW-1:0] prev_wp_nxt;
   wire [AW-1:0] end_base;
   wire [AW-1:0] end_pad;
   wire [AW-1:0] blk_end;
   wire wp_below_prev;
   wire blk_wrapped;
   wire eval;

   // Start follows every waypoint target, even empty ones
   assign blk_start_nxt = wp_valid ? wp_target : blk_start_r;
   assign prev_wp_nxt = wp_valid ? wp_addr : prev_wp_r;

   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         blk_start_r <= tac_pkg::VAL_RST;
      end else begin
         blk_start_r <= blk_start_nxt;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         prev_wp_r <= tac_pkg::VAL_RST;
      end else begin
         prev_wp_r <= prev_wp_nxt;
      end
   end

   assign end_base = wp_exception ? wp_last_addr : wp_addr;
   // Padding to the last byte still lies below the next instruction
   assign end_pad = wp_insn_half ? tac_pkg::END_PAD_HALF
                                 : tac_pkg::END_PAD_WORD;
   assign blk_end = end_base | end_pad;
   assign wp_below_prev = wp_addr < prev_wp_r;
   assign blk_wrapped = wp_direct_flow && wp_below_prev;
   assign eval = wp_valid && !wp_empty;

   // ****************************************
   // Access-type qualifiers
   // ****************************************
   // One qualifier per comparator; range use takes only the low comparator's
   wire [NC-1:0] acc_ok;
   genvar g;
   generate
      for (g = 0; g < NC; g++) begin : g_acc
         assign acc_ok[g] = access_ok(accesses[g*CW +: CW], ctx_match);
      end
   endgenerate

   // ****************************************
   // Single-address matchers
   // ****************************************
   wire [NC-1:0] sam_span;
   wire [NC-1:0] sam_hit;
   wire [NC-1:0] sam_ev_nxt;
   generate
      for (g = 0; g < NC; g++) begin : g_sam
         wire [AW-1:0] v = values[g*AW +: AW];
         // Address span covers any executed instruction, cond or not
         assign sam_span[g] = in_span(v, blk_start_r, blk_end);
         assign sam_hit[g] = sam_span[g] && acc_ok[g];
      end
   endgenerate

   // One-cycle event in the cycle after the waypoint strobe
   assign sam_ev_nxt = eval ? sam_hit : '0;

   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         single_address_matcher_ev <= '0;
      end else begin
         single_address_matcher_ev <= sam_ev_nxt;
      end
   end

   // ****************************************
   // Range matchers
   // ****************************************
   wire [NP-1:0] lo_ok;
   wire [NP-1:0] inc_span;
   wire [NP-1:0] exc_span;
   wire [NP-1:0] inc_hit;
   wire [NP-1:0] exc_hit;
   wire [NP-1:0] rng_ev_nxt;
   wire [NP-1:0] exc_ev_nxt;
   generate
      for (g = 0; g < NP; g++) begin : g_rng
         // Low half is the odd-numbered comparator, high half the even
         wire [AW-1:0] lo = values[(2*g)*AW +: AW];
         wire [AW-1:0] hi = values[(2*g+1)*AW +: AW];
         assign lo_ok[g] = acc_ok[2*g];
         assign inc_span[g] = overlaps(lo, hi, blk_start_r, blk_end);
         assign exc_span[g] = covers(lo, hi, blk_start_r, blk_end);
      end
   endgenerate

   // A wrapped block never hits, a safe and simple answer
   assign inc_hit = blk_wrapped ? '0 : (inc_span & lo_ok);
   assign exc_hit = blk_wrapped ? '0 : (exc_span & lo_ok);
   // Held to the next evaluated waypoint; cpu_reset is not looked at
   assign rng_ev_nxt = eval ? inc_hit : range_matcher_ev;
   assign exc_ev_nxt = eval ? exc_hit : range_exclude_hit;

   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         range_matcher_ev <= '0;
      end else begin
         range_matcher_ev <= rng_ev_nxt;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         range_exclude_hit <= '0;
      end else begin
         range_exclude_hit <= exc_ev_nxt;
      end
   end

   // ****************************************
   // Trace gate range term
   // ****************************************
   wire inc_any;
   wire exc_any;
   wire gate_inc;
   wire gate_exc;
   wire gate_mode;
   wire gate_nxt;
   assign inc_any = |(inc_hit & range_select);
   assign exc_any = |(exc_hit & range_select);
   assign gate_inc = inc_any;
   // Exclusion only bites when a selected range holds the whole block
   assign gate_exc = !exc_any;
   assign gate_mode = include_mode ? gate_inc : gate_exc;
   assign gate_nxt = eval ? gate_mode : trace_gate_range_ok;

   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         trace_gate_range_ok <= 1'b0;
      end else begin
         trace_gate_range_ok <= gate_nxt;
      end
   end

   wire unused_ok = cpu_reset;
endmodule : tac_top
`default_nettype wire

// ===== verif/tac_chk.sv
// Port assertions for the address comparator unit
`default_nettype none
module tac_chk (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic wp_valid,
   input wire logic wp_empty,
   input wire logic [7:0] range_select,
   input wire logic include_mode,
   input wire logic [15:0] single_address_matcher_ev,
   input wire logic [7:0] range_matcher_ev,
   input wire logic [7:0] range_exclude_hit,
   input wire logic trace_gate_range_ok
);
   wire logic sgl = |single_address_matcher_ev;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   sequence s_eval; wp_valid && !wp_empty; endsequence
   sequence s_skip; wp_valid && wp_empty; endsequence
   property p_cause; sgl |-> $past(wp_valid && !wp_empty); endproperty
   a_cause: assert property (p_cause)
      else $error("single event with no waypoint");
   property p_pulse; sgl && !wp_valid |=> !sgl; endproperty
   a_pulse: assert property (p_pulse)
      else $error("single event too long");
   property p_hold; !wp_valid |=> $stable(range_matcher_ev); endproperty
   a_hold: assert property (p_hold)
      else $error("range event moved");
   property p_xhold; !wp_valid |=> $stable(range_exclude_hit); endproperty
   a_xhold: assert property (p_xhold)
      else $error("exclude hit moved");
   property p_ghold; !wp_valid |=> $stable(trace_gate_range_ok); endproperty
   a_ghold: assert property (p_ghold)
      else $error("gate moved");
   property p_skip; s_skip |=> !sgl && $stable(range_matcher_ev); endproperty
   a_skip: assert property (p_skip)
      else $error("empty block changed results");
   property p_inc; s_eval ##0 include_mode |=>
      trace_gate_range_ok == |(range_matcher_ev & $past(range_select));
   endproperty
   a_inc: assert property (p_inc)
      else $error("include gate wrong");
   property p_exc; s_eval ##0 !include_mode |=>
      trace_gate_range_ok == !(|(range_exclude_hit & $past(range_select)));
   endproperty
   a_exc: assert property (p_exc)
      else $error("exclude gate wrong");
endmodule : tac_chk
bind tac_top tac_chk u_chk (.*);
`default_nettype wire

// ===== verif/tac_cpu_model.sv
// Processor-side waypoint source
`default_nettype none
module tac_cpu_model (
   input wire logic sys_clk,
   output logic wp_valid,
   output logic [31:0] wp_addr,
   output logic [31:0] wp_target,
   output logic wp_exception,
   output logic [31:0] wp_last_addr,
   output logic wp_insn_half,
   output logic wp_direct_flow,
   output logic wp_empty,
   output logic cpu_reset
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      {wp_valid, wp_exception, wp_insn_half, wp_direct_flow} = '0;
      {wp_empty, cpu_reset, wp_addr, wp_target, wp_last_addr} = '0;
   end
   // Flags f: exception, half, direct flow, empty
   task automatic step(input logic [31:0] a, t, l, input logic [3:0] f);
      @(posedge sys_clk);
      #1;
      {wp_addr, wp_target, wp_last_addr} = {a, t, l};
      {wp_exception, wp_insn_half, wp_direct_flow, wp_empty} = f;
      cpu_reset = f[0]; // A reset leaves an empty block
      wp_valid = 1'b1;
      @(posedge sys_clk);
      #1;
      wp_valid = 1'b0;
      cpu_reset = 1'b0;
      // Stale fields inverted so nothing leans on old values
      {wp_addr, wp_target, wp_last_addr} = ~{a, t, l};
      {wp_exception, wp_insn_half, wp_direct_flow, wp_empty} = ~f;
   endtask : step
endmodule : tac_cpu_model
`default_nettype wire

// ===== verif/tac_top_test.sv
// Self-checking bench for the address comparator unit
`default_nettype none
module tac_top_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk, arst_n, wp_valid, wp_exception, wp_insn_half;
   logic wp_direct_flow, wp_empty, cpu_reset, cfg_wr, include_mode;
   logic trace_gate_range_ok;
   logic [31:0] wp_addr, wp_target, wp_last_addr, cfg_value, cfg_rd_value;
   logic [3:0] ctx_match, cfg_idx, cfg_access;
   logic [7:0] range_select, range_matcher_ev, range_exclude_hit;
   logic [15:0] single_address_matcher_ev;
   int err_count, num_checks;
   tac_top dut (.*);
   tac_cpu_model cpu (.*);
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic check(input string n, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : check
   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report
   task automatic cfg(input logic [3:0] i, input logic [31:0] v,
         input logic [3:0] a);
      @(posedge sys_clk);
      #1;
      {cfg_wr, cfg_idx, cfg_value, cfg_access} = {1'b1, i, v, a};
      @(posedge sys_clk);
      #1;
      cfg_wr = 1'b0;
      @(posedge sys_clk);
      #1;
      check("readback", v, cfg_rd_value);
   endtask : cfg
   task automatic expect_out(input logic [15:0] s, input logic [7:0] r, x,
         input logic g);
      check("single", s, single_address_matcher_ev);
      check("range", r, range_matcher_ev);
      check("exclude", x, range_exclude_hit);
      check("gate", g, trace_gate_range_ok);
      @(posedge sys_clk);
      #1;
      check("single_next", 0, single_address_matcher_ev);
      check("range_next", r, range_matcher_ev);
   endtask : expect_out
   task automatic t_blocks;
      include_mode = 1'b1;
      cpu.step(32'h1000, 32'h2000, 32'h0, 4'h0);
      expect_out(16'hFFF0, 8'h00, 8'h00, 1'b0);
      cpu.step(32'h2100, 32'h3000, 32'h0, 4'h0);
      expect_out(16'h0003, 8'h01, 8'h00, 1'b1);
   endtask : t_blocks
   task automatic t_ctx_exc;
      cpu.step(32'h7000, 32'h3000, 32'h3010, 4'h8);
      expect_out(16'h0000, 8'h00, 8'h00, 1'b0);
      include_mode = 1'b0;
      ctx_match = 4'hF;
      cpu.step(32'h3100, 32'h3020, 32'h0, 4'h4);
      expect_out(16'h0004, 8'h02, 8'h02, 1'b0);
   endtask : t_ctx_exc
   task automatic t_empty;
      cpu.step(32'h3200, 32'h2080, 32'h0, 4'h1);
      expect_out(16'h0000, 8'h02, 8'h02, 1'b0);
   endtask : t_empty
   task automatic t_wrap;
      include_mode = 1'b1;
      cpu.step(32'h2090, 32'h0200, 32'h0, 4'h2);
      expect_out(16'h0000, 8'h00, 8'h00, 1'b0);
   endtask : t_wrap
   initial begin
      {arst_n, cfg_wr, include_mode, cfg_idx, cfg_value, cfg_access} = '0;
      ctx_match = 4'h0;
      range_select = 8'h03;
      err_count = 0;
      num_checks = 0;
      repeat (3) @(posedge sys_clk);
      #1;
      arst_n = 1'b1;
      repeat (3) @(posedge sys_clk);
      cfg(4'h0, 32'h2050, 4'h0);
      cfg(4'h1, 32'h2100, 4'h0);
      cfg(4'h2, 32'h3000, 4'h4);
      cfg(4'h3, 32'h4000, 4'h4);
      t_blocks();
      t_ctx_exc();
      t_empty();
      t_wrap();
      final_report();
   end
   initial begin
      #20000;
      err_count++;
      final_report();
   end
endmodule : tac_top_test
`default_nettype wire
